// file: logic/twmt_pkg.sv
/*
 * Package for the two-wire master transmit sequencer: register offsets,
 * control and status field positions, status codes and bus timing counts.
 * Assumes a 200 MHz system clock.
 */
package twmt_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_STATUS  = 3'h1;
    localparam logic [2:0] ADDR_DATA    = 3'h2;
    localparam logic [2:0] ADDR_IRQ_ST  = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MSK = 3'h4;
    localparam logic [2:0] ADDR_PRESC   = 3'h5;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTL_DONE  = 7;
    localparam int CTL_START = 5;
    localparam int CTL_STOP  = 4;
    localparam int CTL_COLL  = 3;
    localparam int CTL_EN    = 2;

    // ------------------------------------------------------------------
    // Status codes, upper five bits of the status register
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_START      = 8'h08;
    localparam logic [7:0] CODE_RESTART    = 8'h10;
    localparam logic [7:0] CODE_ADDR_ACKED = 8'h18;
    localparam logic [7:0] CODE_ADDR_NACK  = 8'h20;
    localparam logic [7:0] CODE_DATA_ACKED = 8'h28;
    localparam logic [7:0] CODE_DATA_NACK  = 8'h30;
    localparam logic [7:0] CODE_IDLE       = 8'hf8;
    localparam logic [7:0] CODE_MASK       = 8'hf8;

    // ------------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------------
    localparam int IRQ_DONE = 0;
    localparam int IRQ_NACK = 1;
    localparam int IRQ_COLL = 2;
    localparam int IRQ_BITS = 3;

    // ------------------------------------------------------------------
    // Timing: one quarter of an SCL period in system clock cycles
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_PS  = 5000;
    localparam int         QUARTER_NS     = 625;
    localparam int         QUARTER_CYC    = (QUARTER_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0] PRESC_RESET    = 8'(QUARTER_CYC - 1);

    typedef enum logic [3:0] {
        TWMT_IDLE    = 4'b0000,
        TWMT_START   = 4'b0001,
        TWMT_WAIT    = 4'b0010,
        TWMT_BIT     = 4'b0011,
        TWMT_ACK     = 4'b0100,
        TWMT_STOP    = 4'b0101,
        TWMT_RESTART = 4'b0110
    } twmt_state_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } twmt_req_t;

    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } twmt_pins_t;
endpackage

// file: logic/twmt_sync.sv
/*
 * Two-flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input may change at any time relative to mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module twmt_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic stage1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1 <= 1'b1;
            dout   <= 1'b1;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: logic/twmt_master.sv
/*
 * Two-wire master transmitter sequencer: START, address plus write, data
 * bytes and STOP, pausing on a step-done flag after START and after each acknowledge.
 * Assumes open-drain pins resolved outside and a one-cycle register port.
 */
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module twmt_master (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire twmt_pkg::twmt_req_t req,
    output logic [7:0]             rdata,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output twmt_pkg::twmt_pins_t   pins,
    output logic                   scl_out,
    output logic                   sda_out,
    output logic                   irq
);
    // ------------------------------------------------------------------
    // Synchronised pin inputs
    // ------------------------------------------------------------------
    logic scl_s;
    logic sda_s;

    twmt_sync u_sync_scl (
        .mclk (mclk),
        .rst  (rst),
        .din  (scl_in),
        .dout (scl_s)
    );

    twmt_sync u_sync_sda (
        .mclk (mclk),
        .rst  (rst),
        .din  (sda_in),
        .dout (sda_s)
    );

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic                     step_done;
    logic                     enable;
    logic                     start_req;
    logic                     stop_req;
    logic                     write_coll;
    logic [7:0]               shift_data_register;
    logic [4:0]               serial_status_code;
    logic [1:0]               prescaler_bits;
    logic [7:0]               quarter_div;
    logic [twmt_pkg::IRQ_BITS-1:0] irq_status;
    logic [twmt_pkg::IRQ_BITS-1:0] irq_mask;
    logic                     master_transmit_mode;
    logic                     master_receive_mode;

    twmt_pkg::twmt_state_t state;
    logic [1:0]            phase;
    logic [2:0]            bit_idx;
    logic                  addr_phase;
    logic                  set_done;
    logic [7:0]            set_code;
    logic                  nack_event;

    logic wr_ctl;
    logic wr_data;
    logic clear_done;
    assign wr_ctl     = req.wr && req.addr == twmt_pkg::ADDR_CONTROL;
    assign wr_data    = req.wr && req.addr == twmt_pkg::ADDR_DATA;
    assign clear_done = wr_ctl && req.wdata[twmt_pkg::CTL_DONE];

    // ------------------------------------------------------------------
    // Quarter-bit tick divider
    // ------------------------------------------------------------------
    logic [7:0] div_cnt;
    logic       tick;

    always_ff @(posedge mclk) begin
        if (rst || div_cnt == quarter_div) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Ticks pause while the partner stretches SCL during a released high.
    assign tick = div_cnt == quarter_div && !(scl_out && !scl_s);

    // ------------------------------------------------------------------
    // Control register and step-done flag
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            step_done  <= 1'b0;
            enable     <= 1'b0;
            start_req  <= 1'b0;
            stop_req   <= 1'b0;
        end else begin
            // flag write one clears; set wins
            if (set_done) begin
                step_done <= 1'b1;
            end else if (clear_done) begin
                step_done <= 1'b0;
            end
            if (wr_ctl) begin
                enable    <= req.wdata[twmt_pkg::CTL_EN];
                start_req <= req.wdata[twmt_pkg::CTL_START];
                stop_req  <= req.wdata[twmt_pkg::CTL_STOP];
            end else if (state == twmt_pkg::TWMT_STOP && phase == 2'd3
                         && tick) begin
                stop_req <= 1'b0;
            end
        end
    end

    // Data may only be loaded while the flag is set, else it collides.
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_data_register <= 8'hff;
            write_coll          <= 1'b0;
        end else if (wr_data) begin
            if (step_done) begin
                shift_data_register <= req.wdata;
            end else begin
                write_coll <= 1'b1;
            end
        end else if (wr_ctl && !req.wdata[twmt_pkg::CTL_COLL]) begin
            write_coll <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            quarter_div    <= twmt_pkg::PRESC_RESET;
            prescaler_bits <= 2'b00;
            irq_mask       <= '0;
        end else if (req.wr && req.addr == twmt_pkg::ADDR_PRESC) begin
            quarter_div <= req.wdata;
        end else if (req.wr && req.addr == twmt_pkg::ADDR_STATUS) begin
            prescaler_bits <= req.wdata[1:0];
        end else if (req.wr && req.addr == twmt_pkg::ADDR_IRQ_MSK) begin
            irq_mask <= req.wdata[twmt_pkg::IRQ_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------------
    // Each bit takes four ticks: low setup, rise, high sample, fall.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state                <= twmt_pkg::TWMT_IDLE;
            phase                <= 2'd0;
            bit_idx              <= 3'd7;
            addr_phase           <= 1'b0;
            scl_out              <= 1'b1;
            sda_out              <= 1'b1;
            set_done             <= 1'b0;
            set_code             <= twmt_pkg::CODE_IDLE;
            nack_event           <= 1'b0;
            master_transmit_mode <= 1'b0;
            master_receive_mode  <= 1'b0;
        end else begin
            set_done   <= 1'b0;
            nack_event <= 1'b0;
            if (tick) begin
                phase <= phase + 2'd1;
            end
            case (state)
            twmt_pkg::TWMT_IDLE: begin
                phase <= 2'd0;
                if (enable && start_req && !step_done && scl_s && sda_s) begin
                    state <= twmt_pkg::TWMT_START;
                end
            end
            twmt_pkg::TWMT_START: begin
                if (tick && phase == 2'd1) begin
                    sda_out <= 1'b0;
                end
                if (tick && phase == 2'd3) begin
                    scl_out    <= 1'b0;
                    set_done   <= 1'b1;
                    set_code   <= twmt_pkg::CODE_START;
                    addr_phase <= 1'b1;
                    state      <= twmt_pkg::TWMT_WAIT;
                end
            end
            twmt_pkg::TWMT_WAIT: begin
                phase   <= 2'd0;
                bit_idx <= 3'd7;
                if (!step_done && !set_done) begin
                    if (!enable) begin
                        scl_out <= 1'b1;
                        sda_out <= 1'b1;
                        state   <= twmt_pkg::TWMT_IDLE;
                    end else if (stop_req) begin
                        sda_out <= 1'b0;
                        state   <= twmt_pkg::TWMT_STOP;
                    end else begin
                        sda_out <= shift_data_register[7];
                        state   <= twmt_pkg::TWMT_BIT;
                    end
                end
            end
            twmt_pkg::TWMT_BIT: begin
                if (tick && phase == 2'd0) begin
                    sda_out <= shift_data_register[bit_idx];
                end
                if (tick && phase == 2'd1) begin
                    scl_out <= 1'b1;
                end
                if (tick && phase == 2'd3) begin
                    scl_out <= 1'b0;
                    bit_idx <= bit_idx - 3'd1;
                    if (bit_idx == 3'd0) begin
                        state <= twmt_pkg::TWMT_ACK;
                    end
                end
            end
            twmt_pkg::TWMT_ACK: begin
                if (tick && phase == 2'd0) begin
                    sda_out <= 1'b1;
                end
                if (tick && phase == 2'd1) begin
                    scl_out <= 1'b1;
                end
                if (tick && phase == 2'd2) begin
                    nack_event <= sda_s;
                    if (addr_phase) begin
                        set_code <= sda_s ? twmt_pkg::CODE_ADDR_NACK
                                          : twmt_pkg::CODE_ADDR_ACKED;
                    end else begin
                        set_code <= sda_s ? twmt_pkg::CODE_DATA_NACK
                                          : twmt_pkg::CODE_DATA_ACKED;
                    end
                end
                if (tick && phase == 2'd3) begin
                    scl_out  <= 1'b0;
                    set_done <= 1'b1;
                    state    <= twmt_pkg::TWMT_WAIT;
                    if (addr_phase) begin
                        master_transmit_mode <= !shift_data_register[0];
                        master_receive_mode  <= shift_data_register[0];
                    end
                    addr_phase <= 1'b0;
                end
            end
            twmt_pkg::TWMT_STOP: begin
                if (tick && phase == 2'd1) begin
                    scl_out <= 1'b1;
                end
                if (tick && phase == 2'd2) begin
                    sda_out <= 1'b1;
                end
                if (tick && phase == 2'd3) begin
                    master_transmit_mode <= 1'b0;
                    master_receive_mode  <= 1'b0;
                    state                <= twmt_pkg::TWMT_IDLE;
                end
            end
            default: begin
                state <= twmt_pkg::TWMT_IDLE;
            end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pins <= '0;
        end else begin
            pins.scl_oe <= !scl_out || step_done;
            pins.sda_oe <= !sda_out;
        end
    end

    // ------------------------------------------------------------------
    // Status code capture
    // ------------------------------------------------------------------
    // The code is meaningful only while the flag stands; otherwise idle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            serial_status_code <= twmt_pkg::CODE_IDLE[7:3];
        end else if (set_done) begin
            serial_status_code <= set_code[7:3];
        end else if (!step_done) begin
            serial_status_code <= twmt_pkg::CODE_IDLE[7:3];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic [twmt_pkg::IRQ_BITS-1:0] irq_set;
    logic [twmt_pkg::IRQ_BITS-1:0] irq_clr;
    assign irq_set = {wr_data && !step_done, nack_event, set_done};
    assign irq_clr = (req.wr && req.addr == twmt_pkg::ADDR_IRQ_ST)
                     ? req.wdata[twmt_pkg::IRQ_BITS-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_status <= '0;
            irq         <= 1'b0;
        end else begin
            irq_status <= irq_set | (irq_status & ~irq_clr);
            irq        <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
            twmt_pkg::ADDR_CONTROL: rdata <= {step_done, 1'b0, start_req,
                stop_req, write_coll, enable, 2'b00};
            twmt_pkg::ADDR_STATUS: rdata <= {serial_status_code, 1'b0,
                prescaler_bits};
            twmt_pkg::ADDR_DATA: rdata <= shift_data_register;
            twmt_pkg::ADDR_IRQ_ST: rdata <= {5'b00000, irq_status};
            twmt_pkg::ADDR_IRQ_MSK: rdata <= {5'b00000, irq_mask};
            twmt_pkg::ADDR_PRESC: rdata <= {quarter_div[7:2],
                master_receive_mode, master_transmit_mode};
            default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// file: verification/twmt_monitor.sv
/*
 * Port checker for the two-wire master transmit sequencer.
 * Assumes divider 3 (four-cycle quarter tick) and that software masks
 * every interrupt source except step-done.
 */
`timescale 1ns/10ps
`default_nettype none
module twmt_monitor (
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire twmt_pkg::twmt_req_t  req,
    input wire logic [7:0]           rdata,
    input wire twmt_pkg::twmt_pins_t pins,
    input wire logic                 irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------------
    sequence s_start;
        !pins.scl_oe && $rose(pins.sda_oe);
    endsequence
    sequence s_stop;
        !pins.scl_oe && $fell(pins.sda_oe);
    endsequence

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_reset_quiet;
        disable iff (1'b0) rst |=> !pins.scl_oe && !pins.sda_oe && !irq;
    endproperty
    property p_rdata_idle;
        !req.rd |=> rdata == 8'h00;
    endproperty
    property p_presc_zero;
        req.rd && req.addr == twmt_pkg::ADDR_STATUS |=> rdata[1:0] == 2'b00;
    endproperty
    property p_irq_scl;
        irq |-> pins.scl_oe;
    endproperty
    property p_scl_high;
        $fell(pins.scl_oe) |-> !pins.scl_oe [*4];
    endproperty
    property p_scl_low;
        $rose(pins.scl_oe) |-> pins.scl_oe [*4];
    endproperty
    property p_start;
        s_start |-> ##[1:8] pins.scl_oe;
    endproperty
    property p_stop;
        s_stop |-> !pins.scl_oe [*8];
    endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("bus or irq active after reset");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
    a_presc_zero: assert property (p_presc_zero)
        else $error("status prescaler bits not zero");
    a_irq_scl: assert property (p_irq_scl)
        else $error("clock released while step-done pending");
    a_scl_high: assert property (p_scl_high)
        else $error("clock high phase too short");
    a_scl_low: assert property (p_scl_low)
        else $error("clock low phase too short");
    a_start: assert property (p_start)
        else $error("clock not pulled after start");
    a_stop: assert property (p_stop)
        else $error("bus not idle after stop");
endmodule
`default_nettype wire

// file: verification/twmt_slave_model.sv
/*
 * Behavioural slave receiver on the two-wire bus.
 * Assumes open-drain wires with pull-ups resolved by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module twmt_slave_model (
    input  wire logic  scl,
    input  wire logic  sda,
    input  wire logic  ack_en,
    output logic       sda_oe,
    output logic [7:0] last_byte,
    output logic       stop_seen
);
    int         bits = -1;
    logic       in_ack = 1'b0;
    logic [7:0] sh = 8'h00;

    initial begin
        sda_oe = 1'b0;
        last_byte = 8'h00;
        stop_seen = 1'b0;
    end
    always @(negedge sda) if (scl === 1'b1) begin
        bits = 0;
        stop_seen = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        bits = -1;
        stop_seen = 1'b1;
    end
    always @(posedge scl) if (bits >= 0 && bits < 8) begin
        sh = {sh[6:0], sda};
        bits++;
        if (bits == 8) last_byte = sh;
    end
    always @(negedge scl) begin
        if (in_ack) begin
            in_ack = 1'b0;
            sda_oe = 1'b0;
            bits = 0;
        end else if (bits == 8) begin
            in_ack = 1'b1;
            sda_oe = ack_en;
        end
    end
endmodule
`default_nettype wire

// file: verification/tb.sv
/*
 * Self-checking bench for the two-wire master transmit sequencer.
 * Assumes the slave model and the port checker in this folder.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                 mclk;
    logic                 rst;
    twmt_pkg::twmt_req_t  req;
    logic [7:0]           rdata;
    twmt_pkg::twmt_pins_t pins;
    logic                 irq;
    logic                 ack_en;
    logic                 s_oe;
    logic [7:0]           s_byte;
    logic                 s_stop;
    logic                 m_scl;
    logic                 m_sda;
    int                   mismatches;
    int                   checks_done;

    // Pull-ups: a wire is low while any party pulls it.
    wire scl = ~pins.scl_oe;
    wire sda = ~(pins.sda_oe | s_oe);

    twmt_master dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
        .scl_in(scl), .sda_in(sda), .pins(pins), .scl_out(m_scl),
        .sda_out(m_sda), .irq(irq));
    twmt_slave_model slave (.scl(scl), .sda(sda), .ack_en(ack_en),
        .sda_oe(s_oe), .last_byte(s_byte), .stop_seen(s_stop));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string w, input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge mclk);
        req.wr    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge mclk);
        req.rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e,
                          input string w);
        logic [7:0] v;
        rd(a, v);
        check(w, v, e);
    endtask
    task automatic wait_done;
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 400 && v[7] !== 1'b1; i++)
            rd(twmt_pkg::ADDR_CONTROL, v);
        if (v[7] !== 1'b1) begin
            mismatches++;
            report_and_stop;
        end
    endtask
    // Interrupt status is cleared first so irq never outlives the flag.
    task automatic step(input logic [7:0] ctl, code);
        wr(twmt_pkg::ADDR_IRQ_ST, 8'h07);
        wr(twmt_pkg::ADDR_CONTROL, ctl);
        wait_done;
        rd_chk(twmt_pkg::ADDR_STATUS, code, "status code");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_reset_values;
        rd_chk(twmt_pkg::ADDR_STATUS, 8'hf8, "idle status");
        rd_chk(twmt_pkg::ADDR_CONTROL, 8'h00, "control");
        rd_chk(twmt_pkg::ADDR_DATA, 8'hff, "data");
        rd_chk(twmt_pkg::ADDR_PRESC, 8'h7c, "divider");
        wr(twmt_pkg::ADDR_PRESC, 8'h03);
    endtask
    task automatic s_collision;
        wr(twmt_pkg::ADDR_DATA, 8'h55);
        rd_chk(twmt_pkg::ADDR_CONTROL, 8'h08, "collision");
        rd_chk(twmt_pkg::ADDR_DATA, 8'hff, "discarded");
        rd_chk(twmt_pkg::ADDR_IRQ_ST, 8'h04, "coll event");
        check("irq masked", {7'h0, irq}, 8'h00);
        wr(twmt_pkg::ADDR_CONTROL, 8'h00);
        wr(twmt_pkg::ADDR_IRQ_ST, 8'h04);
    endtask
    task automatic s_transfer(input logic ack);
        logic [7:0] b [3];
        b = '{ack ? 8'ha6 : 8'ha7, 8'h3c, 8'hc3};
        ack_en = ack;
        wr(twmt_pkg::ADDR_IRQ_MSK, {7'h0, ack});
        step(8'ha4, twmt_pkg::CODE_START);
        repeat (24) @(posedge mclk);
        check("scl held", {7'h0, scl}, 8'h00);
        check("scl drive", {7'h0, m_scl}, 8'h00);
        check("irq", {7'h0, irq}, {7'h0, ack});
        rd_chk(twmt_pkg::ADDR_IRQ_ST, 8'h01, "done event");
        for (int i = 0; i < 3; i++) begin
            wr(twmt_pkg::ADDR_DATA, b[i]);
            step(8'h84, i == 0 ? (ack ? 8'h18 : 8'h20)
                               : (ack ? 8'h28 : 8'h30));
            check("byte on wire", s_byte, b[i]);
            if (i == 0)
                rd_chk(twmt_pkg::ADDR_PRESC, {6'h0, !ack, ack}, "mode");
        end
        wr(twmt_pkg::ADDR_IRQ_ST, 8'h07);
        wr(twmt_pkg::ADDR_CONTROL, 8'h94);
        for (int i = 0; i < 200 && !s_stop; i++)
            @(posedge mclk);
        check("stop", {7'h0, s_stop}, 8'h01);
        if (s_stop !== 1'b1)
            report_and_stop;
        rd_chk(twmt_pkg::ADDR_STATUS, 8'hf8, "after stop");
    endtask
    task automatic s_reset_mid;
        wr(twmt_pkg::ADDR_CONTROL, 8'ha4);
        repeat (30) @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check("scl free", {7'h0, scl}, 8'h01);
        check("drive idle", {6'h0, m_scl, m_sda}, 8'h03);
        rd_chk(twmt_pkg::ADDR_STATUS, 8'hf8, "status");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        req = '0;
        ack_en = 1'b1;
        mismatches = 0;
        checks_done = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        s_reset_values;
        s_collision;
        s_transfer(1'b1);
        s_transfer(1'b0);
        s_reset_mid;
        report_and_stop;
    end
endmodule

bind twmt_master twmt_monitor mon (.mclk(mclk), .rst(rst), .req(req),
    .rdata(rdata), .pins(pins), .irq(irq));
`default_nettype wire
